// ### tbm_top.sv
// Test observation multiplexer with its AXI4-Lite register slave.
// Assumes observed signals come from logic on clk; only the pin 0 pad input is
// asynchronous. Analog routing itself lives in the analog macro fed by atb_select.
//
// Contract
// - Low five analog bits pick test pair.
// - Bit 6 turns pin 0 into scan enable.
// - Six digital bits pick triple; pin configured.
// - Both selector registers reset to zero.
// - Code 14 shows oscillator calibration starts.
// - Code 15 shows calibration ready, crystal request.
// - Code 12 shows serial and interrupt aux.
// - Code 26 shows up, down, their XOR.
// - Code 5 shows divider and clock-out enables.
// - Code 2 shows aux converter status.
// - Code 49 shows receive packet engine status.
module tbm_top
  import tbm_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // AXI4-Lite write channels.
  input wire logic [tbm_pkg::TBM_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels.
  input wire logic [tbm_pkg::TBM_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pin configuration from the pin control block.
  input wire logic [tbm_pkg::TBM_PINS-1:0] gpio_mux_cfg,
  // Observed internal signals.
  input wire logic aux_converter_enable,
  input wire logic aux_conv_ready_n,
  input wire logic aux_conv_done,
  input wire logic clkdiv_enable_sync,
  input wire logic clkout_enable,
  input wire logic clkout_enable_sync,
  input wire logic ser_out_aux_select,
  input wire logic ser_out_aux,
  input wire logic irq_aux_select,
  input wire logic rc_full_cal_start,
  input wire logic rc_fine_cal_start,
  input wire logic rc_xtal_request,
  input wire logic rc_coarse_ready,
  input wire logic rc_fine_ready,
  input wire logic rc_xtal_request_sync,
  input wire logic pfd_up,
  input wire logic pfd_down,
  input wire logic rx_packet_engine_enable,
  input wire logic preamble_valid,
  input wire logic packet_searching,
  // General-purpose pins 0 to 2.
  input wire logic [tbm_pkg::TBM_PINS-1:0] gpio_in,
  output logic [tbm_pkg::TBM_PINS-1:0] gpio_out,
  output logic [tbm_pkg::TBM_PINS-1:0] gpio_oe_n,
  // Scan enable and analog test pair select.
  output logic scan_enable_input,
  output logic [tbm_pkg::TBM_ATB_W-1:0] atb_select
);

  import tbm_pkg::*;

  logic [7:0] analog_probe_select;
  logic [7:0] digital_probe_select;
  logic aw_got;
  logic w_got;
  logic [TBM_ADDR_W-1:0] aw_addr;
  logic [7:0] w_byte;
  logic w_lane0;
  logic gpio0_sync;
  logic [TBM_PINS-1:0] mux_sel;
  logic aw_fire;
  logic w_fire;
  logic b_fire;
  logic ar_fire;
  logic r_fire;
  logic do_write;
  logic next_aw_got;
  logic next_w_got;
  logic next_bvalid;
  logic next_rvalid;
  logic scan_mode;

  // ----------------------------------------------------------------
  // Write channel
  // ----------------------------------------------------------------
  assign aw_fire = s_axi_awvalid & s_axi_awready;
  assign w_fire = s_axi_wvalid & s_axi_wready;
  assign b_fire = s_axi_bvalid & s_axi_bready;
  assign do_write = aw_got & w_got & ~s_axi_bvalid;
  assign next_aw_got = b_fire ? 1'b0 : (aw_got | aw_fire);
  assign next_w_got = b_fire ? 1'b0 : (w_got | w_fire);
  assign next_bvalid = b_fire ? 1'b0 : (s_axi_bvalid | do_write);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= '0;
      w_byte <= 8'h00;
      w_lane0 <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= TBM_RESP_OKAY;
    end else begin
      aw_got <= next_aw_got;
      w_got <= next_w_got;
      s_axi_bvalid <= next_bvalid;
      s_axi_awready <= ~next_aw_got & ~next_bvalid;
      s_axi_wready <= ~next_w_got & ~next_bvalid;
      if (aw_fire) begin
        aw_addr <= s_axi_awaddr;
      end
      if (w_fire) begin
        w_byte <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[0];
      end
      if (do_write) begin
        s_axi_bresp <= (tbm_decode(aw_addr) == TBM_SEL_NONE) ? TBM_RESP_DECERR : TBM_RESP_OKAY;
      end
    end
  end

  // ----------------------------------------------------------------
  // Selector registers
  // ----------------------------------------------------------------
  // zero after reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      analog_probe_select <= TBM_ANALOG_RST;
      digital_probe_select <= TBM_DIGITAL_RST;
    end else if (do_write && w_lane0) begin
      unique case (tbm_decode(aw_addr))
        TBM_SEL_ANALOG: analog_probe_select <= w_byte;
        TBM_SEL_DIGITAL: digital_probe_select <= w_byte;
        TBM_SEL_NONE: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  assign ar_fire = s_axi_arvalid & s_axi_arready;
  assign r_fire = s_axi_rvalid & s_axi_rready;
  assign next_rvalid = r_fire ? 1'b0 : (s_axi_rvalid | ar_fire);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= TBM_RESP_OKAY;
    end else begin
      s_axi_rvalid <= next_rvalid;
      s_axi_arready <= ~next_rvalid;
      if (ar_fire) begin
        unique case (tbm_decode(s_axi_araddr))
          TBM_SEL_ANALOG: begin
            s_axi_rdata <= {24'h00_0000, analog_probe_select};
            s_axi_rresp <= TBM_RESP_OKAY;
          end
          TBM_SEL_DIGITAL: begin
            s_axi_rdata <= {24'h00_0000, digital_probe_select};
            s_axi_rresp <= TBM_RESP_OKAY;
          end
          TBM_SEL_NONE: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= TBM_RESP_DECERR;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Analog pair select
  // ----------------------------------------------------------------
  // low five bits
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      atb_select <= '0;
    end else begin
      atb_select <= analog_probe_select[TBM_ATB_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Digital triple select
  // ----------------------------------------------------------------
  // The pins are registered from the held selector, so a write shows one clock later.
  always_comb begin
    unique case (digital_probe_select[TBM_DTB_W-1:0])
      TBM_DTB_ADC: mux_sel = {aux_conv_done, aux_conv_ready_n, aux_converter_enable};
      TBM_DTB_CLKDIV: mux_sel = {clkout_enable_sync, clkout_enable, clkdiv_enable_sync};
      TBM_DTB_SER_AUX: mux_sel = {irq_aux_select, ser_out_aux, ser_out_aux_select};
      TBM_DTB_RC_START: mux_sel = {rc_xtal_request, rc_fine_cal_start, rc_full_cal_start};
      TBM_DTB_RC_RDY: mux_sel = {rc_xtal_request_sync, rc_fine_ready, rc_coarse_ready};
      TBM_DTB_PFD: mux_sel = {pfd_up ^ pfd_down, pfd_down, pfd_up};
      TBM_DTB_RX_PH: mux_sel = {packet_searching, preamble_valid, rx_packet_engine_enable};
      default: mux_sel = '0;
    endcase
  end

  assign scan_mode = digital_probe_select[TBM_SCAN_BIT];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gpio_out <= '0;
      gpio_oe_n <= '1;
    end else begin
      gpio_out <= mux_sel & gpio_mux_cfg & {2'b11, ~scan_mode};
      gpio_oe_n <= ~(gpio_mux_cfg & {2'b11, ~scan_mode});
    end
  end

  // ----------------------------------------------------------------
  // Scan enable input
  // ----------------------------------------------------------------
  tbm_sync #(
    .WIDTH(1)
  ) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .async_in(gpio_in[0]),
    .sync_out(gpio0_sync)
  );

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      scan_enable_input <= 1'b0;
    end else begin
      scan_enable_input <= scan_mode & gpio0_sync;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_sel_reset: assert property (@(posedge clk) !rst_n |=>
    (analog_probe_select == 8'h00 && digital_probe_select == 8'h00))
    else $error("selectors not zero after reset");
  chk_atb_follow: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 atb_select == $past(analog_probe_select[4:0]))
    else $error("analog pair select does not follow register");
  chk_scan_pin: assert property (@(posedge clk) disable iff (!rst_n)
    scan_mode |=> gpio_oe_n[0] && scan_enable_input == $past(gpio0_sync))
    else $error("pin 0 not released to scan enable");
  chk_cfg_gate: assert property (@(posedge clk) disable iff (!rst_n)
    !gpio_mux_cfg[1] |=> gpio_oe_n[1] && !gpio_out[1])
    else $error("unconfigured pin driven");
  chk_rc_start: assert property (@(posedge clk) disable iff (!rst_n)
    (digital_probe_select[6:0] == {1'h0, TBM_DTB_RC_START} && gpio_mux_cfg == 3'h7)
    |=> gpio_out == {$past(rc_xtal_request), $past(rc_fine_cal_start), $past(rc_full_cal_start)})
    else $error("code 14 triple wrong");
  chk_rc_ready: assert property (@(posedge clk) disable iff (!rst_n)
    (digital_probe_select[6:0] == {1'h0, TBM_DTB_RC_RDY} && gpio_mux_cfg == 3'h7)
    |=> gpio_out[2] == $past(rc_xtal_request_sync) && gpio_out[0] == $past(rc_coarse_ready))
    else $error("code 15 triple wrong");
  chk_aux_sel: assert property (@(posedge clk) disable iff (!rst_n)
    (digital_probe_select[6:0] == {1'h0, TBM_DTB_SER_AUX} && gpio_mux_cfg == 3'h7)
    |=> gpio_out[1] == $past(ser_out_aux) && gpio_out[2] == $past(irq_aux_select))
    else $error("code 12 triple wrong");
  chk_pfd_xor: assert property (@(posedge clk) disable iff (!rst_n)
    (digital_probe_select[6:0] == {1'h0, TBM_DTB_PFD} && gpio_mux_cfg == 3'h7)
    |=> gpio_out[2] == (gpio_out[0] ^ gpio_out[1]) && gpio_out[0] == $past(pfd_up))
    else $error("code 26 triple wrong");
  chk_clk_div: assert property (@(posedge clk) disable iff (!rst_n)
    (digital_probe_select[6:0] == {1'h0, TBM_DTB_CLKDIV} && gpio_mux_cfg == 3'h7)
    |=> gpio_out[1] == $past(clkout_enable) && gpio_out[0] == $past(clkdiv_enable_sync))
    else $error("code 5 triple wrong");
  chk_adc_status: assert property (@(posedge clk) disable iff (!rst_n)
    (digital_probe_select[6:0] == {1'h0, TBM_DTB_ADC} && gpio_mux_cfg == 3'h7)
    |=> gpio_out[1] == $past(aux_conv_ready_n) && gpio_out[2] == $past(aux_conv_done))
    else $error("code 2 triple wrong");
  chk_rx_engine: assert property (@(posedge clk) disable iff (!rst_n)
    (digital_probe_select[6:0] == {1'h0, TBM_DTB_RX_PH} && gpio_mux_cfg == 3'h7)
    |=> gpio_out[0] == $past(rx_packet_engine_enable) && gpio_out[2] == $past(packet_searching))
    else $error("code 49 triple wrong");
  chk_undef_zero: assert property (@(posedge clk) disable iff (!rst_n)
    (digital_probe_select[5:0] == 6'h3F) |=> gpio_out == 3'h0)
    else $error("undefined code drives pins");
  chk_write_reach: assert property (@(posedge clk) disable iff (!rst_n)
    (do_write && w_lane0 && tbm_decode(aw_addr) == TBM_SEL_DIGITAL && gpio_mux_cfg == 3'h7
     && $stable(gpio_mux_cfg))
    |=> digital_probe_select == $past(w_byte) ##1 gpio_oe_n[2] == 1'b0)
    else $error("digital write not seen at pins in time");
  chk_bresp_pair: assert property (@(posedge clk) disable iff (!rst_n)
    do_write |=> s_axi_bvalid [*1] ##0 !s_axi_awready && !s_axi_wready)
    else $error("write answer missing");

  cov_write: cover property (@(posedge clk) disable iff (!rst_n) b_fire);
  cov_read: cover property (@(posedge clk) disable iff (!rst_n) r_fire);
  cov_scan: cover property (@(posedge clk) disable iff (!rst_n) scan_enable_input);
  cov_pfd: cover property (@(posedge clk) disable iff (!rst_n)
    digital_probe_select[5:0] == 6'h1A && gpio_out[2]);

endmodule

// ### tbm_pkg.sv
// Constants shared by the test observation multiplexer.
// Assumes a 32-bit AXI4-Lite register bus with 12 address bits.
package tbm_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int TBM_ADDR_W = 12;
  localparam logic [9:0] TBM_ANALOG_IDX = 10'h050;
  localparam logic [9:0] TBM_DIGITAL_IDX = 10'h051;
  localparam logic [7:0] TBM_ANALOG_RST = 8'h00;
  localparam logic [7:0] TBM_DIGITAL_RST = 8'h00;

  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam int TBM_ATB_W = 5;
  localparam int TBM_DTB_W = 6;
  localparam int TBM_SCAN_BIT = 6;
  localparam int TBM_PINS = 3;

  // ----------------------------------------------------------------
  // Digital selection codes
  // ----------------------------------------------------------------
  localparam logic [5:0] TBM_DTB_ADC = 6'h02;
  localparam logic [5:0] TBM_DTB_CLKDIV = 6'h05;
  localparam logic [5:0] TBM_DTB_SER_AUX = 6'h0C;
  localparam logic [5:0] TBM_DTB_RC_START = 6'h0E;
  localparam logic [5:0] TBM_DTB_RC_RDY = 6'h0F;
  localparam logic [5:0] TBM_DTB_PFD = 6'h1A;
  localparam logic [5:0] TBM_DTB_RX_PH = 6'h31;

  // ----------------------------------------------------------------
  // Bus responses
  // ----------------------------------------------------------------
  localparam logic [1:0] TBM_RESP_OKAY = 2'h0;
  localparam logic [1:0] TBM_RESP_DECERR = 2'h3;

  typedef enum logic [1:0] {
    TBM_SEL_NONE = 2'h0,
    TBM_SEL_ANALOG = 2'h1,
    TBM_SEL_DIGITAL = 2'h2
  } tbm_sel_t;

  // Decodes a word address into the register it names.
  function automatic tbm_sel_t tbm_decode(input logic [TBM_ADDR_W-1:0] addr);
    if (addr[TBM_ADDR_W-1:2] == TBM_ANALOG_IDX) begin
      return TBM_SEL_ANALOG;
    end else if (addr[TBM_ADDR_W-1:2] == TBM_DIGITAL_IDX) begin
      return TBM_SEL_DIGITAL;
    end
    return TBM_SEL_NONE;
  endfunction

endpackage

// ### tbm_sync.sv
// Two-flop synchroniser for levels arriving from pins.
// Assumes the input is a slow level; pulses shorter than one clock may be lost.
module tbm_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Asynchronous level in, synchronised level out.
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  // Refuses a width that leaves nothing to synchronise.
  if (WIDTH < 1) begin : g_width_check
    $error("tbm_sync needs WIDTH of at least one");
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stage1 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule

// ### tbm_pin_tester.sv
// Bench-side tester standing on general-purpose pins 0 to 2.
// Assumes active-low pin enables from the device; it drives only pins the device releases.
module tbm_pin_tester
(
  // Clock.
  input wire logic clk,
  // Level the tester offers on pin 0 as scan enable.
  input wire logic scan_level,
  // Device pin drivers.
  input wire logic [2:0] gpio_out,
  input wire logic [2:0] gpio_oe_n,
  // Resolved pin levels.
  output logic [2:0] gpio_in
);
  timeunit 1ns;
  timeprecision 1ns;

  // --------------------------------------------------------------
  // Released pins
  // --------------------------------------------------------------
  // Released pins 1 and 2 toggle every cycle so a stale value is never seen.
  logic [1:0] toggle = 2'b01;

  always @(posedge clk) begin
    toggle <= ~toggle;
  end

  always_comb begin
    gpio_in[0] = gpio_oe_n[0] ? scan_level : gpio_out[0];
    for (int i = 1; i < 3; i++) begin
      gpio_in[i] = gpio_oe_n[i] ? toggle[i-1] : gpio_out[i];
    end
  end
endmodule

// ### tbm_tb.sv
// Self-checking bench for the test observation multiplexer.
// Assumes tbm_pkg, tbm_top and the pin tester are compiled before it.
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin failures++; \
  $display("[ERR] %0t mismatch got %h exp %h", $time, (g), (e)); end end

module testbench
  import tbm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // --------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------
  localparam logic [11:0] A_AN = {TBM_ANALOG_IDX, 2'b00};
  localparam logic [11:0] A_DG = {TBM_DIGITAL_IDX, 2'b00};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] awaddr = '0;
  logic [11:0] araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = 4'hF;
  logic [2:0] cfg = '0;
  logic [19:0] obs = '0;
  logic scan_lvl = 1'b0;
  wire awready, wready, bvalid, arready, rvalid, scan_en;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [2:0] gpio_in, gpio_out, gpio_oe_n;
  wire [4:0] atb;
  int failures = 0;
  int n_checks = 0;
  int seed = 3;
  logic [7:0] an, dg;
  logic [1:0] resp;
  logic [31:0] rd;
  int codes[$] = '{2, 5, 12, 14, 15, 26, 49, 0, 13, 63};

  always #10 clk = ~clk;

  tbm_top dut_u (
    .clk(clk), .rst_n(rst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .gpio_mux_cfg(cfg),
    .aux_converter_enable(obs[0]), .aux_conv_ready_n(obs[1]), .aux_conv_done(obs[2]),
    .clkdiv_enable_sync(obs[3]), .clkout_enable(obs[4]), .clkout_enable_sync(obs[5]),
    .ser_out_aux_select(obs[6]), .ser_out_aux(obs[7]), .irq_aux_select(obs[8]),
    .rc_full_cal_start(obs[9]), .rc_fine_cal_start(obs[10]), .rc_xtal_request(obs[11]),
    .rc_coarse_ready(obs[12]), .rc_fine_ready(obs[13]), .rc_xtal_request_sync(obs[14]),
    .pfd_up(obs[15]), .pfd_down(obs[16]), .rx_packet_engine_enable(obs[17]),
    .preamble_valid(obs[18]), .packet_searching(obs[19]),
    .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n),
    .scan_enable_input(scan_en), .atb_select(atb)
  );

  tbm_pin_tester tester_u (
    .clk(clk), .scan_level(scan_lvl), .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n),
    .gpio_in(gpio_in)
  );

  // --------------------------------------------------------------
  // Bus tasks and reference model
  // --------------------------------------------------------------
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      t++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && t < 100);
    resp = bresp;
    bready <= 1'b0;
    if (t >= 100) failures++;
  endtask

  task automatic rdr(input logic [11:0] a);
    int t;
    t = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      t++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && t < 100);
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
    if (t >= 100) failures++;
  endtask

  function automatic logic [2:0] triple(input int c, input logic [19:0] o);
    case (c)
      2: return o[2:0];
      5: return o[5:3];
      12: return o[8:6];
      14: return o[11:9];
      15: return o[14:12];
      26: return {o[15] ^ o[16], o[16], o[15]};
      49: return o[19:17];
      default: return 3'b000;
    endcase
  endfunction

  task automatic pins(input int c, input logic sc);
    logic [2:0] eo, en;
    eo = triple(c, obs) & cfg;
    en = ~cfg;
    if (sc) begin
      eo[0] = 1'b0;
      en[0] = 1'b1;
    end
    `CHK(gpio_out, eo)
    `CHK(gpio_oe_n, en)
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rdr(A_AN);
    `CHK(rd, 32'h0)
    rdr(A_DG);
    `CHK(rd, 32'h0)
    `CHK({atb, gpio_out, gpio_oe_n, scan_en}, 12'h00E)
    $display("test reset done");
    for (int k = 0; k < 4; k++) begin
      an = 8'($random(seed));
      wr(A_AN, ($random(seed) & 32'hFFFFFF00) | an);
      `CHK(resp, TBM_RESP_OKAY)
      rdr(A_AN);
      `CHK(rd, {24'h0, an})
      `CHK(atb, an[4:0])
    end
    $display("test analog done");
    wr(12'h148, 32'h0000_00FF);
    `CHK(resp, TBM_RESP_DECERR)
    rdr(12'h148);
    `CHK({resp, rd}, {TBM_RESP_DECERR, 32'h0})
    wstrb <= 4'hE;
    wr(A_AN, 32'h0000_00FF);
    `CHK(resp, TBM_RESP_OKAY)
    wstrb <= 4'hF;
    rdr(A_AN);
    `CHK(rd, {24'h0, an})
    $display("test unmapped done");
    for (int k = 0; k < 3 * codes.size(); k++) begin
      dg = 8'(codes[k % codes.size()]) | (8'($random(seed)) & 8'h80);
      @(posedge clk);
      obs <= 20'($random(seed));
      cfg <= (k % 3 == 0) ? 3'b111 : 3'($random(seed));
      wr(A_DG, ($random(seed) & 32'hFFFFFF00) | dg);
      #1;
      pins(int'(dg[5:0]), 1'b0);
      rdr(A_DG);
      `CHK(rd, {24'h0, dg})
      `CHK(resp, TBM_RESP_OKAY)
    end
    $display("test digital done");
    @(posedge clk);
    scan_lvl <= 1'b1;
    cfg <= 3'b111;
    wr(A_DG, 32'h0000_005A);
    repeat (5) @(posedge clk);
    #1;
    `CHK(scan_en, 1'b1)
    pins(26, 1'b1);
    @(posedge clk);
    scan_lvl <= 1'b0;
    repeat (5) @(posedge clk);
    #1;
    `CHK(scan_en, 1'b0)
    @(posedge clk);
    scan_lvl <= 1'b1;
    cfg <= 3'b110;
    wr(A_DG, 32'h0000_001A);
    repeat (5) @(posedge clk);
    #1;
    `CHK(scan_en, 1'b0)
    $display("test scan done");
    close_out();
  end

  initial begin
    #400000;
    failures++;
    close_out();
  end
endmodule
